// ---- logic/msp_serial_unit.sv ----
/*
 Five-channel serial unit: async or clocked channels, APB registers,
 bit-oriented receive on the fifth channel in its own clock domain.
 Assumes an APB master on mclk and pin inputs unrelated to mclk.
*/
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
module msp_serial_unit (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [4:0]  rx_pin,
   output logic [4:0]       tx_pin,
   output logic [4:0]       channel_serial_clock,
   output logic [4:0]       channel_serial_clock_oe_b,
   input  wire logic        first_channel_serial_clock_in,
   output logic             secondary_clock_pin_c,
   output logic             secondary_clock_pin_c_oe_b,
   output logic             clock_pin_d,
   output logic             clock_pin_d_oe_b,
   input  wire logic        fifth_channel_receive_clock
);
   localparam int N = msp_pkg::NCH;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
      logic [N-1:0]                 en;
      logic [N-1:0]                 clk_mode;
      logic [N-1:0]                 seven;
      logic [N-1:0]                 ninth;
      logic [N-1:0]                 brk_inh;
      logic [N-1:0][15:0]           div;
      logic                         gpo;
      logic                         gpoe;
      logic                         hdlc;
      logic                         ir;
      logic                         cfg;
      logic [N-1:0][10:0]           tx_sh;
      logic [N-1:0][15:0]           tx_cnt;
      logic [N-1:0][3:0]            tx_n;
      logic [N-1:0]                 tx_busy;
      logic [N-1:0]                 tx_q;
      logic [N-1:0][10:0]           rx_sh;
      logic [N-1:0][15:0]           rx_cnt;
      logic [N-1:0][3:0]            rx_n;
      msp_pkg::msp_rx_type [N-1:0]  rx_st;
      logic [N-1:0][8:0]            rx_dat;
      logic [N-1:0]                 rx_full;
      logic [N-1:0]                 rx_ovr;
      logic [N-1:0]                 sclk;
      logic [N-1:0]                 sclk_oe_b;
      logic                         sec_c;
      logic                         sec_c_oe_b;
      logic                         pin_d;
      logic                         pin_d_oe_b;
      logic                         tog_d;
   } msp_state_type;
   msp_state_type r;
   msp_state_type next_r;

   logic [6:0] pin_s;
   logic [1:0] lk_cfg;
   logic [7:0] bit_byte;
   logic       bit_tog;

   // ---------------------------------------------------------------
   // Character helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] data_len(input logic seven,
                                           input logic ninth);
      data_len = (seven ? 4'h7 : 4'h8) + {3'h0, ninth};
   endfunction : data_len

   function automatic logic [10:0] char_frame(input logic [8:0] d,
                                              input logic       seven,
                                              input logic       ninth);
      logic [3:0] dl;
      dl = data_len(seven, 1'b0);
      char_frame = '1;
      char_frame[0] = 1'b0;
      for (int k = 0; k < 8; k++) begin
         if (4'(k) < dl) begin
            char_frame[k+1] = d[k];
         end
      end
      if (ninth) begin
         char_frame[dl+4'h1] = d[8];
      end
   endfunction : char_frame

   function automatic logic [8:0] char_data(input logic [10:0] raw,
                                            input logic        seven,
                                            input logic        ninth);
      logic [3:0] dl;
      dl = data_len(seven, 1'b0);
      char_data = '0;
      for (int k = 0; k < 8; k++) begin
         if (4'(k) < dl) begin
            char_data[k] = raw[k+1];
         end
      end
      if (ninth) begin
         char_data[8] = raw[dl+4'h1];
      end
   endfunction : char_data

   // ---------------------------------------------------------------
   // Synchronisers and link-domain receiver
   // ---------------------------------------------------------------
   msp_sync #(
      .W    (7),
      .INIT (7'h3f)
   ) u_pin_sync (
      .clk   (mclk),
      .rst_b (rst_b),
      .d     ({bit_tog, first_channel_serial_clock_in, rx_pin}),
      .q     (pin_s)
   );

   // Link clock may stop; config is a level, so two flops suffice
   msp_sync #(
      .W    (2),
      .INIT (2'h0)
   ) u_link_sync (
      .clk   (fifth_channel_receive_clock),
      .rst_b (1'b1),
      .d     ({r.ir, r.hdlc & r.en[N-1] & r.cfg}),
      .q     (lk_cfg)
   );

   msp_bitrx u_bitrx (
      .lclk   (fifth_channel_receive_clock),
      .en     (lk_cfg[0]),
      .ir     (lk_cfg[1]),
      .din    (rx_pin[N-1]),
      .byte_o (bit_byte),
      .tog    (bit_tog)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] dv;
      logic [15:0] hf;
      logic [3:0]  nb;
      logic [10:0] raw;
      logic [8:0]  dw;
      logic        go;
      logic        en;
      logic        rxs;
      logic        acc;
      logic        hit;
      logic [2:0]  ch;
      dv = msp_pkg::DIV_MIN;
      hf = '0;
      nb = '0;
      raw = '0;
      dw = '0;
      go = 1'b0;
      en = 1'b0;
      rxs = 1'b1;
      next_r = r;
      ch = paddr[6:4];
      hit = !paddr[7] && (ch < 3'(N));
      acc = psel && penable && r.pready && !r.pslverr;

      // APB: no wait states, read data captured in setup
      next_r.pready = psel && !penable;
      next_r.pslverr = psel && !penable && !hit;
      if (psel && !penable) begin
         next_r.prdata = '0;
         if (hit) begin
            case (paddr[3:0])
               msp_pkg::OFS_DATA: next_r.prdata[8:0] = r.rx_dat[ch];
               msp_pkg::OFS_STAT: begin
                  next_r.prdata[msp_pkg::ST_FULL] = r.rx_full[ch];
                  next_r.prdata[msp_pkg::ST_BUSY] = r.tx_busy[ch];
                  next_r.prdata[msp_pkg::ST_OVR] = r.rx_ovr[ch];
                  next_r.prdata[msp_pkg::ST_LOW] = !pin_s[ch];
                  next_r.prdata[msp_pkg::ST_RXACT] =
                     (r.rx_st[ch] != msp_pkg::RX_IDLE);
               end
               msp_pkg::OFS_CTRL: begin
                  next_r.prdata[msp_pkg::CTRL_EN] = r.en[ch];
                  next_r.prdata[msp_pkg::CTRL_CLK] = r.clk_mode[ch];
                  next_r.prdata[msp_pkg::CTRL_SEVEN] = r.seven[ch];
                  next_r.prdata[msp_pkg::CTRL_NINTH] = r.ninth[ch];
                  next_r.prdata[31:16] = r.div[ch];
               end
               msp_pkg::OFS_EXT: begin
                  next_r.prdata[msp_pkg::EXT_BRKINH] = r.brk_inh[ch];
                  if (ch == 3'h0) begin
                     next_r.prdata[msp_pkg::EXT_GPO] = r.gpo;
                     next_r.prdata[msp_pkg::EXT_GPOE] = r.gpoe;
                     next_r.prdata[msp_pkg::EXT_GPI] = pin_s[5];
                  end
                  if (ch == 3'(N-1)) begin
                     next_r.prdata[msp_pkg::EXT_HDLC] = r.hdlc;
                     next_r.prdata[msp_pkg::EXT_IR] = r.ir;
                     next_r.prdata[msp_pkg::EXT_CFG] = r.cfg;
                  end
               end
               default: next_r.pslverr = 1'b1;
            endcase
         end
      end

      if (acc && pwrite && paddr[3:0] == msp_pkg::OFS_CTRL) begin
         next_r.en[ch] = pwdata[msp_pkg::CTRL_EN];
         next_r.clk_mode[ch] = pwdata[msp_pkg::CTRL_CLK];
         next_r.seven[ch] = pwdata[msp_pkg::CTRL_SEVEN];
         next_r.ninth[ch] = pwdata[msp_pkg::CTRL_NINTH];
         next_r.div[ch] = pwdata[31:16];
      end
      if (acc && pwrite && paddr[3:0] == msp_pkg::OFS_EXT) begin
         next_r.brk_inh[ch] = pwdata[msp_pkg::EXT_BRKINH];
         if (ch == 3'h0) begin
            next_r.gpo = pwdata[msp_pkg::EXT_GPO];
            next_r.gpoe = pwdata[msp_pkg::EXT_GPOE];
         end
         if (ch == 3'(N-1)) begin
            next_r.hdlc = pwdata[msp_pkg::EXT_HDLC];
            next_r.ir = pwdata[msp_pkg::EXT_IR];
            next_r.cfg = pwdata[msp_pkg::EXT_CFG];
         end
      end
      // Reading data frees the holding register; a new char wins
      if (acc && !pwrite && paddr[3:0] == msp_pkg::OFS_DATA) begin
         next_r.rx_full[ch] = 1'b0;
         next_r.rx_ovr[ch] = 1'b0;
      end

      // Channels
      for (int i = 0; i < N; i++) begin
         en = r.en[i] && (i != N-1 || r.cfg);
         dv = (r.div[i] < msp_pkg::DIV_MIN) ? msp_pkg::DIV_MIN
                                            : r.div[i];
         hf = dv >> 1;
         rxs = pin_s[i];
         nb = data_len(r.seven[i], r.ninth[i]) + 4'h2;
         go = 1'b0;
         dw = '0;

         // Transmit shifter, also the clocked-mode engine
         if (r.tx_busy[i]) begin
            if (r.tx_cnt[i] == 16'h0) begin
               next_r.tx_sh[i] = {1'b1, r.tx_sh[i][10:1]};
               next_r.tx_n[i] = r.tx_n[i] - 4'h1;
               next_r.tx_cnt[i] = dv - 16'h1;
               if (r.tx_n[i] == 4'h1) begin
                  next_r.tx_busy[i] = 1'b0;
                  if (r.clk_mode[i]) begin
                     go = 1'b1;
                     dw = {1'b0, r.rx_sh[i][10:3]};
                  end
               end
            end else begin
               next_r.tx_cnt[i] = r.tx_cnt[i] - 16'h1;
            end
            if (r.clk_mode[i] && r.tx_cnt[i] == hf) begin
               next_r.rx_sh[i] = {rxs, r.rx_sh[i][10:1]};
            end
            if (!en) begin
               next_r.tx_busy[i] = 1'b0;
            end
         end else if (acc && pwrite && en && ch == 3'(i)
                      && paddr[3:0] == msp_pkg::OFS_DATA) begin
            next_r.tx_busy[i] = 1'b1;
            next_r.tx_cnt[i] = dv - 16'h1;
            if (r.clk_mode[i]) begin
               next_r.tx_sh[i] = {3'h7, pwdata[7:0]};
               next_r.tx_n[i] = msp_pkg::CLK_BITS;
            end else begin
               next_r.tx_sh[i] = char_frame(pwdata[8:0], r.seven[i],
                                            r.ninth[i]);
               next_r.tx_n[i] = nb;
            end
         end
         next_r.tx_q[i] = !r.tx_busy[i] || r.tx_sh[i][0];

         // Serial clock pin: low first half of each bit, idles high; channel 0 outside clocked mode drives gpo
         next_r.sclk[i] = !(r.tx_busy[i] && r.clk_mode[i]
                            && r.tx_cnt[i] >= hf);
         next_r.sclk_oe_b[i] = !(en && r.clk_mode[i]);
         if (i == 0 && !(en && r.clk_mode[0])) begin
            next_r.sclk[0] = r.gpo;
            next_r.sclk_oe_b[0] = !r.gpoe;
         end

         // Asynchronous receiver
         case (r.rx_st[i])
            msp_pkg::RX_IDLE: begin
               if (en && !r.clk_mode[i] && !(i == N-1 && r.hdlc)
                   && !rxs) begin
                  next_r.rx_st[i] = msp_pkg::RX_BITS;
                  next_r.rx_cnt[i] = hf;
                  next_r.rx_n[i] = nb;
               end
            end
            msp_pkg::RX_BITS: begin
               if (r.rx_cnt[i] == 16'h0) begin
                  next_r.rx_sh[i] = {rxs, r.rx_sh[i][10:1]};
                  next_r.rx_n[i] = r.rx_n[i] - 4'h1;
                  next_r.rx_cnt[i] = dv - 16'h1;
                  if (r.rx_n[i] == 4'h1) begin
                     raw = next_r.rx_sh[i] >> (4'hb - nb);
                     dw = char_data(raw, r.seven[i], r.ninth[i]);
                     next_r.rx_st[i] = msp_pkg::RX_IDLE;
                     if (!raw[nb-4'h1] && dw == '0 && r.brk_inh[i]) begin
                        next_r.rx_st[i] = msp_pkg::RX_BREAK;
                     end else begin
                        go = 1'b1;
                     end
                  end
               end else begin
                  next_r.rx_cnt[i] = r.rx_cnt[i] - 16'h1;
               end
               if (!en) begin
                  next_r.rx_st[i] = msp_pkg::RX_IDLE;
               end
            end
            msp_pkg::RX_BREAK: begin
               if (rxs || !en) begin
                  next_r.rx_st[i] = msp_pkg::RX_IDLE;
               end
            end
            default: next_r.rx_st[i] = msp_pkg::RX_IDLE;
         endcase

         // Bytes from the link domain; toggle seen past both flops
         if (i == N-1 && r.hdlc && en && pin_s[6] != r.tog_d) begin
            go = 1'b1;
            dw = {1'b0, bit_byte};
         end

         if (go) begin
            if (next_r.rx_full[i]) begin
               next_r.rx_ovr[i] = 1'b1;
            end else begin
               next_r.rx_dat[i] = dw;
               next_r.rx_full[i] = 1'b1;
            end
         end
      end
      next_r.tog_d = pin_s[6];

      next_r.sec_c = next_r.sclk[2];
      next_r.sec_c_oe_b = next_r.sclk_oe_b[2];
      next_r.pin_d = next_r.sclk[3];
      next_r.pin_d_oe_b = next_r.sclk_oe_b[3];

      if (!rst_b) begin
         next_r = '0;
         next_r.div = {N{msp_pkg::DIV_RST}};
         next_r.tx_q = '1;
         next_r.sclk = '1;
         next_r.sclk_oe_b = '1;
         next_r.sec_c = 1'b1;
         next_r.sec_c_oe_b = 1'b1;
         next_r.pin_d = 1'b1;
         next_r.pin_d_oe_b = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      r <= next_r;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign tx_pin = r.tx_q;
   assign channel_serial_clock = r.sclk;
   assign channel_serial_clock_oe_b = r.sclk_oe_b;
   assign secondary_clock_pin_c = r.sec_c;
   assign secondary_clock_pin_c_oe_b = r.sec_c_oe_b;
   assign clock_pin_d = r.pin_d;
   assign clock_pin_d_oe_b = r.pin_d_oe_b;
endmodule : msp_serial_unit

// ---- pkg/msp_pkg.sv ----
/*
 Constants, field layout and state types of the multi-mode serial unit.
 Assumes a single system clock for the register side and a link clock
 for the bit-oriented receiver of the fifth channel.
*/
package msp_pkg;
   localparam int NCH = 5;
   // ------------------------------------------------------------------
   // Register offsets within a channel, channel at paddr[6:4]
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_DATA = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_CTRL = 4'h8;
   localparam logic [3:0] OFS_EXT  = 4'hc;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_EN    = 0;
   localparam int CTRL_CLK   = 1;
   localparam int CTRL_SEVEN = 2;
   localparam int CTRL_NINTH = 3;
   localparam int CTRL_DIV   = 16;
   localparam int EXT_GPO    = 0;
   localparam int EXT_BRKINH = 1;
   localparam int EXT_GPOE   = 2;
   localparam int EXT_HDLC   = 3;
   localparam int EXT_IR     = 4;
   localparam int EXT_CFG    = 5;
   localparam int EXT_GPI    = 6;
   localparam int ST_FULL    = 0;
   localparam int ST_BUSY    = 1;
   localparam int ST_OVR     = 2;
   localparam int ST_LOW     = 3;
   localparam int ST_RXACT   = 4;
   // ------------------------------------------------------------------
   // Values and counts
   // ------------------------------------------------------------------
   localparam logic [15:0] DIV_MIN    = 16'h0008;
   localparam logic [15:0] DIV_RST    = 16'h01b2;
   localparam logic [3:0]  CLK_BITS   = 4'h8;
   localparam logic [7:0]  FLAG       = 8'h7e;
   localparam logic [2:0]  ONES_STUFF = 3'h5;
   localparam logic [2:0]  ONES_ABORT = 3'h6;
   typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_BREAK} msp_rx_type;
endpackage : msp_pkg

// ---- logic/msp_sync.sv ----
/*
 Two-stage synchroniser of a bus of independent levels.
 Assumes each bit is a level or a toggle; no word coherence.
*/
`timescale 1ns/10ps
module msp_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } msp_sync_type;
   msp_sync_type r;
   msp_sync_type next_r;

   always_comb begin
      next_r.s1 = d;
      next_r.s2 = r.s1;
      if (!rst_b) begin
         next_r.s1 = INIT;
         next_r.s2 = INIT;
      end
   end

   always_ff @(posedge clk) begin
      r <= next_r;
   end

   assign q = r.s2;
endmodule : msp_sync

// ---- logic/msp_bitrx.sv ----
/*
 Bit-oriented frame receiver of the fifth channel, on the link clock.
 Assumes en and ir arrive already synchronised to the link clock.
*/
`timescale 1ns/10ps
module msp_bitrx (
   input  wire logic lclk,
   input  wire logic en,
   input  wire logic ir,
   input  wire logic din,
   output logic [7:0] byte_o,
   output logic       tog
);
   typedef struct packed {
      logic       din_q;
      logic [7:0] hist;
      logic [7:0] sh;
      logic [2:0] ones;
      logic [2:0] cnt;
      logic       inf;
      logic [7:0] byte_o;
      logic       tog;
   } msp_bitrx_type;
   msp_bitrx_type r;
   msp_bitrx_type next_r;

   always_comb begin
      logic b;
      b = r.din_q ^ ir;
      next_r = r;
      next_r.din_q = din;
      next_r.hist = {b, r.hist[7:1]};
      next_r.ones = b ? ((r.ones == 3'h7) ? r.ones : r.ones + 3'h1) : 3'h0;
      if (next_r.hist == msp_pkg::FLAG) begin
         next_r.inf = 1'b1;
         next_r.cnt = 3'h0;
      end else if (b && r.ones == msp_pkg::ONES_ABORT) begin
         next_r.inf = 1'b0;
      end else if (!b && r.ones == msp_pkg::ONES_STUFF) begin
         next_r.inf = r.inf; // Stuffed zero dropped
      end else if (r.inf) begin
         next_r.sh = {b, r.sh[7:1]};
         next_r.cnt = r.cnt + 3'h1;
         if (r.cnt == 3'h7) begin
            next_r.byte_o = {b, r.sh[7:1]};
            next_r.tog = ~r.tog;
         end
      end
      if (!en) begin
         next_r = '0;
      end
   end

   always_ff @(posedge lclk) begin
      r <= next_r;
   end

   assign byte_o = r.byte_o;
   assign tog = r.tog;
endmodule : msp_bitrx

// ---- verification/msp_serial_unit_chk.sv ----
/* Port checker of the serial unit.
 Assumes a bind onto msp_serial_unit, divider 8 where clocks run. */
`timescale 1ns/10ps
module msp_serial_unit_chk (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [4:0] tx_pin,
   input wire logic [4:0] channel_serial_clock,
   input wire logic [4:0] channel_serial_clock_oe_b,
   input wire logic       secondary_clock_pin_c,
   input wire logic       clock_pin_d_oe_b
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("ready without setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error outside access");
   chk_reset_idle: assert property ($rose(rst_b) |->
      tx_pin == 5'h1f && channel_serial_clock_oe_b == 5'h1f)
      else $error("pins not idle after reset");
   chk_start_len: assert property ($fell(tx_pin[1]) |=> !tx_pin[1] [*7])
      else $error("start bit too short");
   // Exact half bit, so a wrong divider shows here
   chk_clk_half: assert property ($fell(channel_serial_clock[3]) |=>
      !channel_serial_clock[3] [*3] ##1 channel_serial_clock[3])
      else $error("clock low phase wrong");
   chk_pin_c_copy: assert property (
      secondary_clock_pin_c == channel_serial_clock[2] ||
      secondary_clock_pin_c == $past(channel_serial_clock[2]))
      else $error("secondary clock differs");
   chk_pin_d_drive: assert property (
      clock_pin_d_oe_b == channel_serial_clock_oe_b[3] ||
      clock_pin_d_oe_b == $past(channel_serial_clock_oe_b[3]))
      else $error("pin d enable differs");
endmodule : msp_serial_unit_chk
bind msp_serial_unit msp_serial_unit_chk chk (.mclk, .rst_b, .psel,
   .penable, .pready, .pslverr, .tx_pin, .channel_serial_clock,
   .channel_serial_clock_oe_b, .secondary_clock_pin_c, .clock_pin_d_oe_b);

// ---- verification/msp_line_peer.sv ----
/* Peer async device on one line.
 Assumes the unit's mclk and a bit period of DIV cycles. */
`timescale 1ns/10ps
module msp_line_peer #(parameter int DIV = 8) (
   input  wire logic mclk,
   input  wire logic tx,
   output logic      rx
);
   // ----
   // Line tasks, called just after a rising edge
   // ----
   initial rx = 1'b1;
   task automatic level(input logic v);
      rx <= v;
   endtask : level
   task automatic send(input logic [8:0] c, input int n);
      rx <= 1'b0;
      repeat (DIV) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         rx <= c[i];
         repeat (DIV) @(posedge mclk);
      end
      rx <= 1'b1;
      repeat (DIV) @(posedge mclk);
   endtask : send
   task automatic recv(output logic [8:0] c, output logic s,
                       input int n, output logic ok);
      c = '0;
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++) begin
         @(posedge mclk);
         ok = (tx === 1'b0);
      end
      repeat (DIV / 2) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         repeat (DIV) @(posedge mclk);
         c[i] = tx;
      end
      repeat (DIV) @(posedge mclk);
      s = tx;
   endtask : recv
endmodule : msp_line_peer

// ---- verification/msp_serial_unit_bench.sv ----
/* Self-checking bench of the serial unit.
 Assumes msp_line_peer on channel 1 and the checker bound. */
`timescale 1ns/10ps
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module msp_serial_unit_bench;
   typedef struct packed {
      logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
   } msp_row_type;
   logic        mclk, rst_b, psel, penable, pwrite, ck0, lclk, lrun, hd;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr, s, ok, prx, pc, pc_oe_b, pd_oe_b, pd;
   logic [4:0]  tx_pin, sclk, sclk_oe_b;
   logic [8:0]  c, got;
   int          err_total, checks, i, n;
   msp_row_type rows [8];
   always #10 mclk = ~mclk;
   always #6 if (lrun) lclk = ~lclk;
   msp_serial_unit dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_pin({hd, 2'b11, prx, 1'b1}),
      .tx_pin, .channel_serial_clock(sclk), .channel_serial_clock_oe_b(sclk_oe_b),
      .first_channel_serial_clock_in(ck0), .secondary_clock_pin_c(pc),
      .secondary_clock_pin_c_oe_b(pc_oe_b), .clock_pin_d(pd),
      .clock_pin_d_oe_b(pd_oe_b), .fifth_channel_receive_clock(lclk));
   msp_line_peer #(.DIV(8)) peer (.mclk, .tx(tx_pin[1]), .rx(prx));
   // ----
   // Tasks
   // ----
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      for (k = 0; k < 16; k++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rdat = prdata; rerr = pslverr;
      psel <= 0; penable <= 0;
      if (k == 16) begin err_total++; complete_run(); end
   endtask : apb
   // Link clock runs only while a frame is on the line
   // Receive data drives rx_pin[4]; the link clock has its own port, fifth_channel_receive_clock
   task automatic frame;
      logic [39:0] v;
      v = {8'hff, 8'h7e, 8'ha5, 8'h7e, 8'hff};
      lrun = 1;
      for (int k = 0; k < 40; k++) begin @(negedge lclk); hd = v[k]; end
      @(negedge lclk); lrun = 0;
      repeat (12) @(posedge mclk);
   endtask : frame
   // ----
   // Sequence
   // ----
   initial begin
      mclk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; ck0 = 0; lclk = 0; lrun = 0; hd = 1; err_total = 0; checks = 0;
      rows = '{'{0, 8'h08, 0, 32'h01b20000, 0}, '{1, 8'h18, 32'h00040001, 0, 0},
         '{0, 8'h18, 0, 32'h00040001, 0}, '{1, 8'h14, '1, 0, 0},
         '{0, 8'h14, 0, 0, 0}, '{0, 8'h50, 0, 0, 1},
         '{0, 8'h02, 0, 0, 1}, '{1, 8'h88, 32'h1, 0, 1}};
      repeat (16) @(posedge mclk);
      rst_b <= 1;
      for (i = 0; i < 8; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w && !rows[i].e) `CHK("rdata", rows[i].x, rdat)
         `CHK("slverr", rows[i].e, rerr)
      end
      $display("register rows done");
      for (i = 0; i < 3; i++) begin
         n = (i == 1) ? 7 : (i == 2) ? 9 : 8;
         c = 9'h1a5 & ((9'h1 << n) - 9'h1);
         apb(1, 8'h18, {16'h0004, 12'h0, i == 2, i == 1, 2'b01});
         apb(1, 8'h10, {23'h0, c});
         peer.recv(got, s, n, ok);
         `CHK("tx char", c, got)
         `CHK("tx stop", 2'b11, {ok, s})
         repeat (8) @(posedge mclk);
         peer.send(c, n);
         apb(0, 8'h10, 0);
         `CHK("rx char", c, rdat[8:0])
      end
      $display("async modes done");
      apb(1, 8'h18, 32'h00080001);
      for (i = 0; i < 2; i++) begin
         apb(1, 8'h1c, {30'h0, i == 0, 1'b0});
         peer.level(0);
         repeat (200) @(posedge mclk);
         apb(0, 8'h14, 0);
         `CHK("line low", 1'b1, rdat[3])
         peer.level(1);
         repeat (40) @(posedge mclk);
         apb(0, 8'h14, 0);
         `CHK("break full", i == 1, rdat[0])
      end
      apb(0, 8'h10, 0);
      `CHK("break data", 9'h0, rdat[8:0])
      $display("break done");
      apb(1, 8'h28, 32'h00080003);
      apb(1, 8'h38, 32'h00080003);
      apb(1, 8'h20, 32'ha5);
      apb(1, 8'h30, 32'h3c);
      `CHK("pins drive", 4'h0, {pc_oe_b, pd_oe_b, sclk_oe_b[3:2]})
      repeat (20) @(posedge mclk);
      `CHK("pin d", sclk[3], pd)
      repeat (60) @(posedge mclk);
      $display("clocked done");
      ck0 <= 1;
      apb(1, 8'h08, 32'h01b20001);
      apb(1, 8'h0c, 32'h4);
      repeat (2) @(posedge mclk);
      `CHK("gpio out", 2'b00, {sclk_oe_b[0], sclk[0]})
      apb(0, 8'h0c, 0);
      `CHK("gpio in", 1'b1, rdat[6])
      $display("gpio done");
      apb(1, 8'h48, 32'h00080001);
      for (i = 0; i < 2; i++) begin
         apb(1, 8'h4c, i ? 32'h28 : 32'h08);
         frame();
         apb(0, 8'h44, 0);
         `CHK("frame full", i[0], rdat[0])
      end
      apb(0, 8'h40, 0);
      `CHK("frame data", 8'ha5, rdat[7:0])
      $display("framing done");
      complete_run();
   end
endmodule : msp_serial_unit_bench
